// ==== hw/spi_prog_pkg.sv ====
// What this block does
// - Only enable instruction accepted until enable succeeds
// - Device samples data on rising clock edge
// - Device launches read data on falling edge
// - EEPROM writes self-timed with built-in auto-erase
// - Chip erase fills flash and EEPROM with 0xFF
// - Echo 0x53 during third enable byte
// - Flash page buffer loaded bytewise by low address
// - Write-page commits buffer at five-bit page address
// - EEPROM byte write carries address and data
// - EEPROM page write changes only loaded bytes
// - Read instructions return addressed content on MISO
// - Reset high ends programming, normal operation resumes
// - Decode enable and chip erase patterns
// - Flash read and load prefixes, byte select bit
// - Decode write page and split page address
// - Decode EEPROM read, write and buffer load
// - Decode lock read/write; zero programs a bit
// - Poll returns busy flag in last bit
package spi_prog_pkg;

  // System clock rate and the self-timed wait figures, in their own units.
  localparam int CLK_KHZ = 40000;
  localparam int FLASH_WAIT_US = 4500;
  localparam int EEPROM_WAIT_US = 4000;
  localparam int ERASE_WAIT_US = 9000;
  localparam int FUSE_WAIT_US = 4500;

  // Busy durations as cycle counts, rounded down so the device finishes in time.
  localparam int FLASH_WAIT_CYC = FLASH_WAIT_US * CLK_KHZ / 1000;
  localparam int EEPROM_WAIT_CYC = EEPROM_WAIT_US * CLK_KHZ / 1000;
  localparam int ERASE_WAIT_CYC = ERASE_WAIT_US * CLK_KHZ / 1000;
  localparam int FUSE_WAIT_CYC = FUSE_WAIT_US * CLK_KHZ / 1000;
  localparam int TIMER_W = 20;

  // Memory geometry.
  localparam int FLASH_ADDR_W = 10;
  localparam int FLASH_BYTES = 1024;
  localparam int PAGE_BYTE_W = 5;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_SEL_W = 5;
  localparam int EE_ADDR_W = 6;
  localparam int EE_BYTES = 64;
  localparam int EE_PAGE_W = 2;
  localparam int EE_PAGE_BYTES = 4;
  localparam int LOCK_W = 6;

  // Field positions inside the instruction bytes.
  localparam int HIGH_SEL_BIT = 3;
  localparam int WRITE_LOCK_BIT = 0;

  // Values.
  localparam logic [7:0] ERASED = 8'hff;
  localparam logic [7:0] LOCKED_READ = 8'h00;
  localparam logic [LOCK_W-1:0] LOCK_RESET = 6'h3f;
  localparam logic [1:0] LOCK_PAD = 2'h3;

  // Instruction codes.
  localparam logic [7:0] OP_PREFIX_AC = 8'hac;
  localparam logic [7:0] ENABLE_ECHO = 8'h53;
  localparam logic [2:0] SUB_ERASE = 3'h4;
  localparam logic [2:0] SUB_LOCK_WR = 3'h7;
  localparam logic [3:0] OP_RD_FLASH = 4'h2;
  localparam logic [3:0] OP_LD_FLASH = 4'h4;
  localparam logic [2:0] OP_LOW_ZERO = 3'h0;
  localparam logic [7:0] OP_WR_PAGE = 8'h4c;
  localparam logic [7:0] OP_RD_EE = 8'ha0;
  localparam logic [7:0] OP_WR_EE = 8'hc0;
  localparam logic [7:0] OP_LD_EE = 8'hc1;
  localparam logic [7:0] OP_WR_EE_PAGE = 8'hc2;
  localparam logic [7:0] OP_RD_LOCK = 8'h58;
  localparam logic [7:0] OP_POLL = 8'hf0;

  // Sequencer states for the self-timed operations.
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ERASE = 4'h2,
    ST_COPY = 4'h4,
    ST_WAIT = 4'h8
  } op_state_t;

endpackage

// ==== hw/sync_edge.sv ====
`timescale 1ns/1ps
// Two-flop synchroniser for a group of pins, with edge pulses from the safe stage.
module sync_edge #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Asynchronous pins.
  input wire logic [WIDTH-1:0] async_in,
  // Synchronised level and one-cycle edge pulses.
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] stage1; // Metastable stage, read only by stage two.
  logic [WIDTH-1:0] prev; // Delayed copy of the safe stage for edges.

  // The first stage feeds the second and nothing else.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= INIT;
      level <= INIT;
      prev <= INIT;
    end else begin
      stage1 <= async_in;
      level <= stage1;
      prev <= level;
    end
  end

  // Edges come from the settled stages only.
  assign rise = level & ~prev;
  assign fall = ~level & prev;

endmodule

// ==== hw/spi_prog_port.sv ====
`timescale 1ns/1ps
// Serial programming port: four-byte instructions over a sampled SPI-style link.
module spi_prog_port #(
  parameter int unsigned FLASH_WAIT = spi_prog_pkg::FLASH_WAIT_CYC,
  parameter int unsigned EEPROM_WAIT = spi_prog_pkg::EEPROM_WAIT_CYC,
  parameter int unsigned ERASE_WAIT = spi_prog_pkg::ERASE_WAIT_CYC,
  parameter int unsigned FUSE_WAIT = spi_prog_pkg::FUSE_WAIT_CYC
) (
  // System clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Programming pins, all asynchronous to clk_sys.
  input wire logic reset_pin_n,
  input wire logic sck,
  input wire logic mosi,
  // Serial data out with its drive enable.
  output logic miso,
  output logic miso_oe,
  // Status towards the rest of the chip.
  output logic prog_enabled,
  output logic write_busy,
  output logic cpu_run
);

  // Synchronised pins and edge pulses.
  logic reset_s; // Reset pin level after the synchroniser.
  logic sck_s; // Serial clock level, only used through its edges.
  logic mosi_s; // Data in, sampled at the clock's rising edge.
  logic [2:0] rise_v; // Rising-edge pulses of the three pins.
  logic [2:0] fall_v; // Falling-edge pulses of the three pins.
  logic sck_rise; // One-cycle pulse on a serial clock rise.
  logic sck_fall; // One-cycle pulse on a serial clock fall.
  logic session; // Programming session, reset pin held low.
  // Receive and transmit path.
  logic [7:0] rx_shift; // Bits collected so far, MSB first.
  logic [7:0] rx_byte; // Byte as it stands with the bit now sampled.
  logic [2:0] bit_cnt; // Bit position inside the current byte.
  logic [1:0] byte_cnt; // Byte position inside the instruction.
  logic [7:0] byte1; // Opcode byte.
  logic [7:0] byte2; // Second instruction byte.
  logic [7:0] byte3; // Third instruction byte.
  logic [7:0] tx_shift; // Byte being sent back, MSB first.
  logic [7:0] read_data; // Answer for the fourth byte.
  logic byte_done; // Eighth bit of a byte sampled.
  logic instr_done; // Fourth byte complete, instruction executes.
  // Decoded commands.
  logic enable_hit;
  logic may_exec;
  logic write_ok;
  logic do_erase;
  logic do_lock_wr;
  logic do_ld_flash;
  logic do_wr_page;
  logic do_wr_ee;
  logic do_ld_ee;
  logic do_wr_ee_pg;
  // Nonvolatile contents and buffers.
  logic [7:0] flash_mem [spi_prog_pkg::FLASH_BYTES]; // Program memory bytes.
  logic [7:0] ee_mem [spi_prog_pkg::EE_BYTES]; // EEPROM bytes.
  logic [7:0] page_buf [spi_prog_pkg::PAGE_BYTES]; // Flash page buffer.
  logic [7:0] ee_buf [spi_prog_pkg::EE_PAGE_BYTES]; // EEPROM page buffer.
  logic [spi_prog_pkg::EE_PAGE_BYTES-1:0] ee_mask; // Loaded EEPROM buffer bytes.
  logic [spi_prog_pkg::LOCK_W-1:0] lock_bits; // Lock bits, zero is programmed.
  // Self-timed operation sequencer.
  spi_prog_pkg::op_state_t state;
  logic [spi_prog_pkg::FLASH_ADDR_W-1:0] walk; // Address walker for erase and copy.
  logic [spi_prog_pkg::PAGE_SEL_W-1:0] page_sel; // Page being committed.
  logic [spi_prog_pkg::TIMER_W-1:0] timer; // Remaining busy cycles.

  // pin synchroniser
  // The clock is sampled, so each phase must span several clk_sys cycles.
  sync_edge #(
    .WIDTH(3),
    .INIT(3'h4)
  ) u_pins (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in({reset_pin_n, sck, mosi}),
    .level({reset_s, sck_s, mosi_s}),
    .rise(rise_v),
    .fall(fall_v)
  );

  // session from reset
  // A high reset pin ends the session and clears the link state.
  assign session = ~reset_s;
  assign sck_rise = rise_v[1] & session;
  assign sck_fall = fall_v[1] & session;

  assign rx_byte = {rx_shift[6:0], mosi_s};
  assign byte_done = sck_rise & (bit_cnt == 3'h7);
  assign instr_done = byte_done & (byte_cnt == 2'h3);

  // sample on rise
  // The bit counter advances on every rising clock edge in a session, the byte counter on every eighth.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_shift <= 8'h00;
      bit_cnt <= 3'h0;
      byte_cnt <= 2'h0;
    end else if (!session) begin
      // Counting restarts with each session; there is no other resync.
      rx_shift <= 8'h00;
      bit_cnt <= 3'h0;
      byte_cnt <= 2'h0;
    end else if (sck_rise) begin
      rx_shift <= rx_byte;
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        byte_cnt <= byte_cnt + 2'h1;
      end
    end
  end

  // The first three bytes are held for decoding; the fourth is used live.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      byte1 <= 8'h00;
      byte2 <= 8'h00;
      byte3 <= 8'h00;
    end else if (byte_done) begin
      unique case (byte_cnt)
        2'h0: byte1 <= rx_byte;
        2'h1: byte2 <= rx_byte;
        2'h2: byte3 <= rx_byte;
        2'h3: byte3 <= byte3;
      endcase
    end
  end

  // read answer
  // Built from bytes one to three as the third byte completes.
  always_comb begin
    read_data = 8'h00;
    if (!prog_enabled) begin
      read_data = 8'h00;
    end else if (byte1 == spi_prog_pkg::OP_POLL) begin
      read_data = {7'h00, write_busy};
    end else if (byte1 == spi_prog_pkg::OP_RD_LOCK) begin
      read_data = {spi_prog_pkg::LOCK_PAD, lock_bits};
    end else if (lock_bits[1:0] == 2'h0) begin
      // Both lock bits programmed: memory contents are not revealed.
      read_data = spi_prog_pkg::LOCKED_READ;
    end else if (byte1[7:4] == spi_prog_pkg::OP_RD_FLASH &&
                 byte1[2:0] == spi_prog_pkg::OP_LOW_ZERO) begin
      read_data = flash_mem[{byte2[0], rx_byte, byte1[spi_prog_pkg::HIGH_SEL_BIT]}];
    end else if (byte1 == spi_prog_pkg::OP_RD_EE) begin
      read_data = ee_mem[rx_byte[spi_prog_pkg::EE_ADDR_W-1:0]];
    end
  end

  // echo previous byte
  // Each received byte is sent back during the next, so 0x53 returns in byte three;
  // after byte three the read answer replaces the echo.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift <= 8'h00;
    end else if (!session) begin
      tx_shift <= 8'h00;
    end else if (byte_done) begin
      tx_shift <= (byte_cnt == 2'h2) ? read_data : rx_byte;
    end else if (sck_fall) begin
      tx_shift <= {tx_shift[6:0], 1'b0};
    end
  end

  // launch on fall
  // Within a session the output bit changes only on a falling clock edge.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      miso <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      miso_oe <= session;
      if (!session) begin
        miso <= 1'b0;
      end else if (sck_fall) begin
        miso <= tx_shift[7];
      end
    end
  end

  assign enable_hit = instr_done & (byte1 == spi_prog_pkg::OP_PREFIX_AC) &
                      (byte2 == spi_prog_pkg::ENABLE_ECHO);

  // gate on enable
  // Nothing but the enable runs before it; writes also wait out the busy time.
  assign may_exec = instr_done & prog_enabled & (state == spi_prog_pkg::ST_IDLE);
  assign write_ok = lock_bits[spi_prog_pkg::WRITE_LOCK_BIT];

  assign do_erase = may_exec & (byte1 == spi_prog_pkg::OP_PREFIX_AC) &
                    (byte2[7:5] == spi_prog_pkg::SUB_ERASE);
  assign do_lock_wr = may_exec & (byte1 == spi_prog_pkg::OP_PREFIX_AC) &
                      (byte2[7:5] == spi_prog_pkg::SUB_LOCK_WR);
  assign do_ld_flash = may_exec & (byte1[7:4] == spi_prog_pkg::OP_LD_FLASH) &
                       (byte1[2:0] == spi_prog_pkg::OP_LOW_ZERO);
  assign do_wr_page = may_exec & write_ok & (byte1 == spi_prog_pkg::OP_WR_PAGE);
  assign do_wr_ee = may_exec & write_ok & (byte1 == spi_prog_pkg::OP_WR_EE);
  assign do_ld_ee = may_exec & (byte1 == spi_prog_pkg::OP_LD_EE);
  assign do_wr_ee_pg = may_exec & write_ok & (byte1 == spi_prog_pkg::OP_WR_EE_PAGE);

  // enable flag
  // Set by a correct enable, dropped when the session ends.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prog_enabled <= 1'b0;
    end else if (!session) begin
      prog_enabled <= 1'b0;
    end else if (enable_hit) begin
      prog_enabled <= 1'b1;
    end
  end

  // lock programming
  // Writing zero programs a bit; only a chip erase or a system reset returns them to one.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lock_bits <= spi_prog_pkg::LOCK_RESET;
    end else if (do_erase) begin
      lock_bits <= spi_prog_pkg::LOCK_RESET;
    end else if (do_lock_wr) begin
      lock_bits <= lock_bits & rx_byte[spi_prog_pkg::LOCK_W-1:0];
    end
  end

  // page buffer fill
  // Each load stores one byte at {word, high}; a commit or erase refills with 0xFF.
  always_ff @(posedge clk_sys) begin
    if (state == spi_prog_pkg::ST_ERASE || state == spi_prog_pkg::ST_COPY) begin
      page_buf[walk[spi_prog_pkg::PAGE_BYTE_W-1:0]] <= spi_prog_pkg::ERASED;
    end else if (do_ld_flash) begin
      page_buf[{byte3[3:0], byte1[spi_prog_pkg::HIGH_SEL_BIT]}] <= rx_byte;
    end
  end

  // EEPROM page buffer
  // The mask remembers which bytes were loaded since the last page write or chip erase.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ee_mask <= '0;
    end else if (do_wr_ee_pg || do_erase) begin
      ee_mask <= '0;
    end else if (do_ld_ee) begin
      ee_mask[byte3[spi_prog_pkg::EE_PAGE_W-1:0]] <= 1'b1;
    end
  end

  // Buffer data itself needs no reset: the mask says what is valid.
  always_ff @(posedge clk_sys) begin
    if (do_ld_ee) begin
      ee_buf[byte3[spi_prog_pkg::EE_PAGE_W-1:0]] <= rx_byte;
    end
  end

  // flash erase and commit
  // The walker erases one byte per cycle, or copies the page buffer into place.
  always_ff @(posedge clk_sys) begin
    if (state == spi_prog_pkg::ST_ERASE) begin
      flash_mem[walk] <= spi_prog_pkg::ERASED;
    end else if (state == spi_prog_pkg::ST_COPY) begin
      flash_mem[{page_sel, walk[spi_prog_pkg::PAGE_BYTE_W-1:0]}] <=
        page_buf[walk[spi_prog_pkg::PAGE_BYTE_W-1:0]];
    end
  end

  // EEPROM auto-erase
  // A write replaces the old byte outright, so no separate erase is needed.
  always_ff @(posedge clk_sys) begin
    if (state == spi_prog_pkg::ST_ERASE && walk < 10'(spi_prog_pkg::EE_BYTES)) begin
      ee_mem[walk[spi_prog_pkg::EE_ADDR_W-1:0]] <= spi_prog_pkg::ERASED;
    end else if (do_wr_ee) begin
      ee_mem[byte3[spi_prog_pkg::EE_ADDR_W-1:0]] <= rx_byte;
    end else if (do_wr_ee_pg) begin
      for (int i = 0; i < spi_prog_pkg::EE_PAGE_BYTES; i++) begin
        if (ee_mask[i]) begin
          ee_mem[{byte3[5:2], 2'(i)}] <= ee_buf[i];
        end
      end
    end
  end

  // self-timed sequencer
  // Every write or erase holds busy for its full wait; the walker runs inside it.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= spi_prog_pkg::ST_IDLE;
      walk <= '0;
      page_sel <= '0;
      timer <= '0;
    end else begin
      if (timer != '0) begin
        timer <= timer - 1'b1;
      end
      unique case (state)
        spi_prog_pkg::ST_IDLE: begin
          walk <= '0;
          if (do_erase) begin
            state <= spi_prog_pkg::ST_ERASE;
            timer <= spi_prog_pkg::TIMER_W'(ERASE_WAIT);
          end else if (do_wr_page) begin
            state <= spi_prog_pkg::ST_COPY;
            page_sel <= {byte2[0], byte3[7:4]};
            timer <= spi_prog_pkg::TIMER_W'(FLASH_WAIT);
          end else if (do_wr_ee || do_wr_ee_pg) begin
            state <= spi_prog_pkg::ST_WAIT;
            timer <= spi_prog_pkg::TIMER_W'(EEPROM_WAIT);
          end else if (do_lock_wr) begin
            state <= spi_prog_pkg::ST_WAIT;
            timer <= spi_prog_pkg::TIMER_W'(FUSE_WAIT);
          end
        end
        spi_prog_pkg::ST_ERASE: begin
          walk <= walk + 1'b1;
          if (walk == 10'(spi_prog_pkg::FLASH_BYTES - 1)) begin
            state <= spi_prog_pkg::ST_WAIT;
          end
        end
        spi_prog_pkg::ST_COPY: begin
          walk <= walk + 1'b1;
          if (walk == 10'(spi_prog_pkg::PAGE_BYTES - 1)) begin
            state <= spi_prog_pkg::ST_WAIT;
          end
        end
        spi_prog_pkg::ST_WAIT: begin
          // A shortened wait that ran out during the walk ends here at once.
          if (timer <= spi_prog_pkg::TIMER_W'(1)) begin
            state <= spi_prog_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= spi_prog_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // busy flag
  // Status outputs: busy trails the sequencer by one cycle, and the core runs while the pin
  // is high; a running write still completes after the session closes.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      write_busy <= 1'b0;
      cpu_run <= 1'b0;
    end else begin
      write_busy <= (state != spi_prog_pkg::ST_IDLE);
      cpu_run <= reset_s;
    end
  end

endmodule

// ==== verif/spi_prog_asserts.sv ====
`timescale 1ns/1ps
// Checker on the programming port pins and status outputs.
module spi_prog_asserts #(
  parameter int unsigned EEPROM_WAIT = 20,
  parameter int unsigned ERASE_WAIT = 1100
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Programming pins.
  input wire logic reset_pin_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  // Status.
  input wire logic prog_enabled,
  input wire logic write_busy,
  input wire logic cpu_run
);
  // Cycles spent busy so far; a counter keeps long bounds cheap.
  int unsigned busy_len;
  // Counts while busy and clears when idle.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_len <= 0;
    end else if (write_busy) begin
      busy_len <= busy_len + 1;
    end else begin
      busy_len <= 0;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_run_after_release: assert property (
    reset_pin_n [*5] |-> cpu_run && !miso_oe && !prog_enabled) else $error("session not closed");
  a_session_drives_out: assert property (
    !reset_pin_n [*5] |-> miso_oe && !cpu_run) else $error("session outputs wrong");
  a_miso_after_fall: assert property (
    $changed(miso) && miso_oe && $past(miso_oe) |-> !$past(sck, 3)) else $error("miso not on fall");
  a_busy_needs_en: assert property (
    $rose(write_busy) |-> prog_enabled) else $error("write before enable");
  a_busy_min_len: assert property (
    $fell(write_busy) |-> busy_len >= EEPROM_WAIT) else $error("busy period too short");
  a_busy_max_len: assert property (
    busy_len <= ERASE_WAIT + 1100) else $error("busy period too long");
  a_en_in_session: assert property (
    $rose(prog_enabled) |-> !reset_pin_n && miso_oe) else $error("enable outside session");
  a_en_drop_cause: assert property (
    $fell(prog_enabled) |-> reset_pin_n) else $error("enable lost in session");
  // Main scenarios reached.
  c_enabled: cover property ($rose(prog_enabled));
  c_busy: cover property ($rose(write_busy));
  c_closed: cover property ($fell(prog_enabled));
endmodule

bind spi_prog_port spi_prog_asserts #(.EEPROM_WAIT(EEPROM_WAIT), .ERASE_WAIT(ERASE_WAIT))
  spi_prog_asserts_i (.clk_sys(clk_sys), .rst_n(rst_n), .reset_pin_n(reset_pin_n), .sck(sck),
  .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .prog_enabled(prog_enabled),
  .write_busy(write_busy), .cpu_run(cpu_run));

// ==== verif/spi_programmer.sv ====
`timescale 1ns/1ps
// Behavioural programmer acting as link master; its clock is unrelated to clk_sys.
module spi_programmer (
  // Pins towards the device.
  output logic reset_pin_n,
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  // Half period of the link clock; raised to model a slow programmer.
  int half_ns = 100;
  // Idle: no session and the clock parked low.
  initial begin
    reset_pin_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
  end
  // The settle time is scaled far below the power-up wait so the run stays short.
  // reset and clock low, then settle
  task automatic open_session(input int settle_ns);
    sck = 1'b0;
    reset_pin_n = 1'b0;
    #(settle_ns);
  endtask
  // Releasing the pin ends the session.
  task automatic close_session();
    reset_pin_n = 1'b1;
  endtask
  task automatic xfer(input logic [31:0] cmd, output logic [31:0] rx);
    for (int i = 31; i >= 0; i--) begin
      mosi = cmd[i];
      #(half_ns);
      sck = 1'b1;
      #(half_ns);
      rx[i] = miso;
      sck = 1'b0;
    end
    // The data line shows the inverse once released, so stale bits never pass.
    mosi = ~mosi;
  endtask
endmodule

// ==== verif/tb_serial_program_interface.sv ====
`timescale 1ns/1ps
// Self-checking bench for the serial programming port.
module tb_serial_program_interface;
  // Clock, reset and pins.
  logic clk_sys;
  logic rst_n;
  logic reset_pin_n;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic prog_enabled;
  logic write_busy;
  logic cpu_run;
  // Counters and the last frame received.
  int errors;
  int comparisons;
  logic [31:0] rx;

  // Short self-timed waits keep the run brief.
  spi_prog_port #(.FLASH_WAIT(40), .EEPROM_WAIT(20), .ERASE_WAIT(1100), .FUSE_WAIT(20))
    spi_prog_port_i (.clk_sys(clk_sys), .rst_n(rst_n), .reset_pin_n(reset_pin_n), .sck(sck),
    .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .prog_enabled(prog_enabled),
    .write_busy(write_busy), .cpu_run(cpu_run));
  spi_programmer spi_programmer_i (.reset_pin_n(reset_pin_n), .sck(sck), .mosi(mosi),
    .miso(miso));

  // System clock at 40 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Compares a byte or a zero-extended flag.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One instruction, then time for the synchronised decode to land.
  task automatic send(input logic [31:0] cmd);
    spi_programmer_i.xfer(cmd, rx);
    repeat (6) @(posedge clk_sys);
    // Step off the edge so the next frame's pins never race the sampling flops.
    #2;
  endtask
  // Polls until the write finishes, with a bound.
  task automatic wait_ready();
    for (int n = 0; n < 40; n++) begin
      send(32'hf000_0000);
      if (rx[0] === 1'b0) return;
    end
    errors++;
    $display("ERROR %0t: busy never cleared", $time);
    stop_test();
  endtask
  // Erase is ignored before enable; enable echoes its second byte.
  task automatic t_enable();
    spi_programmer_i.open_session(200);
    send(32'hac80_0000);
    chk({7'h0, write_busy}, 8'h00, "busy before enable");
    send(32'hac53_0000);
    chk(rx[15:8], 8'h53, "enable echo");
    chk({7'h0, prog_enabled}, 8'h01, "enabled");
    chk({7'h0, miso_oe}, 8'h01, "output driven");
  endtask
  // Chip erase blanks both arrays.
  task automatic t_erase();
    send(32'hac80_0000);
    chk({7'h0, write_busy}, 8'h01, "erase busy");
    wait_ready();
    send(32'h2001_3500);
    chk(rx[7:0], 8'hff, "flash blank");
    send(32'ha000_2a00);
    chk(rx[7:0], 8'hff, "eeprom blank");
  endtask
  // Page 19 word 5 over a slow link; the page bit split is exercised.
  task automatic t_flash();
    spi_programmer_i.half_ns = 150;
    send(32'h4000_053c);
    send(32'h4800_05a5);
    send(32'h4c01_3000);
    wait_ready();
    send(32'h2001_3500);
    chk(rx[7:0], 8'h3c, "flash low");
    send(32'h2801_3500);
    chk(rx[7:0], 8'ha5, "flash high");
    send(32'h2000_3500);
    chk(rx[7:0], 8'hff, "other page");
    spi_programmer_i.half_ns = 100;
  endtask
  // Byte writes, then a page write that loads only index 1 of page 2.
  task automatic t_eeprom();
    send(32'hc000_0811);
    wait_ready();
    send(32'hc000_0922);
    wait_ready();
    send(32'hc100_0177);
    send(32'hc200_0800);
    wait_ready();
    send(32'ha000_0800);
    chk(rx[7:0], 8'h11, "unloaded kept");
    send(32'ha000_0900);
    chk(rx[7:0], 8'h77, "loaded byte");
    send(32'hc000_0988);
    wait_ready();
    send(32'ha000_0900);
    chk(rx[7:0], 8'h88, "auto erase");
  endtask
  // Lock bits: programming blocks writes, then reads.
  task automatic t_lock();
    send(32'h5800_0000);
    chk(rx[7:0], 8'hff, "lock reset");
    send(32'hace0_00fe);
    wait_ready();
    send(32'hc000_0933);
    wait_ready();
    send(32'ha000_0900);
    chk(rx[7:0], 8'h88, "write blocked");
    send(32'hace0_00fc);
    wait_ready();
    send(32'h5800_0000);
    chk(rx[7:0], 8'hfc, "lock read");
    send(32'ha000_0900);
    chk(rx[7:0], 8'h00, "read blocked");
  endtask
  // Releasing the reset pin ends the session.
  task automatic t_exit();
    spi_programmer_i.close_session();
    repeat (8) @(posedge clk_sys);
    chk({5'h00, cpu_run, prog_enabled, miso_oe}, 8'h04, "normal run");
  endtask

  // Bound on the whole run.
  initial begin
    #(25 * 60000);
    errors++;
    $display("ERROR %0t: run timed out", $time);
    stop_test();
  end
  // Main sequence.
  initial begin
    errors = 0;
    comparisons = 0;
    rst_n = 1'b0;
    repeat (8) @(posedge clk_sys);
    #2 rst_n = 1'b1;
    repeat (8) @(posedge clk_sys);
    #2;
    t_enable();
    t_erase();
    t_flash();
    t_eeprom();
    t_lock();
    t_exit();
    stop_test();
  end
endmodule
